// [dv/adcc_cell_model.sv]
// Purpose: analog cell and dma counter stand-in
// Assumes: one clock, cell result fixed per channel
// Notes: dma collects a result only while autoTake is high
`timescale 1ns/1ps
module adcc_cell_model (
   // clock
   input wire logic ref_clk,
   // cell side
   input wire logic [1:0] cellChannel,
   output logic [9:0] cellResult,
   // dma side
   input wire logic autoTake,
   input wire logic dmaRequest,
   output logic dmaTaken,
   output logic rxCountZero,
   output logic rxNextCountZero,
   output logic rxCountWrite
);
   // ==================================================================
   // cell and dma
   assign cellResult = {8'hB3, cellChannel};
   assign rxCountZero = 1'b1;
   assign rxNextCountZero = 1'b1;
   assign rxCountWrite = 1'b0;
   initial dmaTaken = 1'b0;
   always @(posedge ref_clk) dmaTaken <= autoTake & dmaRequest;
endmodule : adcc_cell_model

// [dv/adcc_ctrl_top_tb.sv]
// Purpose: self-checking bench of the converter control block
// Assumes: classic single-cycle wishbone master, one clock
// Notes: reads post expected words, checked at ack
`timescale 1ns/1ps
module adcc_ctrl_top_tb;
   import adcc_pkg::*;
   logic ref_clk = 0, rst_n = 0, bus = 0, we = 0, take = 0, ext = 0;
   logic pwr;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, rdat, m;
   logic ack, cnv, dreq, bm, cz, ncz, cw, taken;
   logic [1:0] ch;
   logic [9:0] res, dmaD;
   logic [31:0] q[$];
   int fails = 0, n_compared = 0, seed = 41237;
   adcc_ctrl_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(bus),
      .wb_stb_i(bus), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timerOutA(3'h0), .extTrigPin(ext), .cellResult(res),
      .cellPowerOn(pwr), .cellSample(), .cellConvert(cnv), .cellChannel(ch),
      .rxCountZero(cz), .rxNextCountZero(ncz), .rxCountWrite(cw),
      .dmaTaken(taken), .dmaRequest(dreq), .dmaByteMode(bm), .dmaData(dmaD));
   adcc_cell_model i_cell (.ref_clk(ref_clk), .cellChannel(ch),
      .cellResult(res), .autoTake(take), .dmaRequest(dreq),
      .dmaTaken(taken), .rxCountZero(cz), .rxNextCountZero(ncz),
      .rxCountWrite(cw));
   initial forever #5 ref_clk = ~ref_clk;
   // ==================================================================
   // checking
   task automatic finish_test();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string s, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   always @(posedge ref_clk) if (ack === 1'b1 && we === 1'b0) begin
      chk("read data", q.size() > 0 ? q.pop_front() : 32'hX, rdat);
   end
   // ==================================================================
   // bus and waits
   task automatic wb(input logic w, input logic [7:0] a, logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      bus <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge ref_clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      bus <= 1'b0;
      if (ack !== 1'b1) begin
         fails++;
         finish_test();
      end
   endtask : wb
   task automatic rd(input logic [7:0] a, logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd
   task automatic waitCnv(input logic v);
      int k;
      k = 0;
      while (cnv !== v && k < 400) begin
         @(posedge ref_clk);
         k++;
      end
      if (cnv !== v) begin
         fails++;
         finish_test();
      end
   endtask : waitCnv
   task automatic conv();
      wb(1'b1, OFS_CMD, 32'h2);
      waitCnv(1'b1);
      waitCnv(1'b0);
      repeat (4) @(posedge ref_clk);
   endtask : conv
   // ==================================================================
   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(OFS_MODE, MODE_RESET);
      rd(OFS_FLAGS, 32'h000C_0000);
      rd(8'h08, 32'h0);
      m = $random(seed);
      wb(1'b1, OFS_MODE, m);
      rd(OFS_MODE, m & MODE_WRITE_MASK);
      wb(1'b1, OFS_MODE, 32'h0);
      wb(1'b1, OFS_CHEN_SET, 32'h5);
      wb(1'b1, OFS_CHEN_CLR, 32'h1);
      rd(OFS_CHEN_STATE, 32'h4);
      $display("test registers done");
      // channels are left alone while converting
      conv();
      rd(OFS_FLAGS, 32'h000D_0004);
      chk("power kept", 32'h1, {31'h0, pwr});
      conv();
      rd(OFS_FLAGS, 32'h000F_0404);
      rd(OFS_FLAGS, 32'h000D_0004);
      rd(OFS_LAST, 32'h2CE);
      rd(OFS_FLAGS, 32'h000C_0000);
      $display("test conversion done");
      wb(1'b1, OFS_MODE, 32'h30);
      take <= 1'b1;
      conv();
      chk("dma data", 32'hCE, {22'h0, dmaD});
      chk("byte mode", 32'h1, {31'h0, bm});
      chk("sleep power", 32'h0, {31'h0, pwr});
      rd(OFS_FLAGS, 32'h000C_0000);
      $display("test dma done");
      // external source selected but hardware triggers disabled
      wb(1'b1, OFS_MODE, 32'hC);
      ext <= 1'b1;
      repeat (60) @(posedge ref_clk);
      chk("ignored trigger", 32'h0, {31'h0, pwr});
      ext <= 1'b0;
      wb(1'b1, OFS_MODE, 32'hD);
      ext <= 1'b1;
      waitCnv(1'b1);
      waitCnv(1'b0);
      repeat (4) @(posedge ref_clk);
      ext <= 1'b0;
      chk("trigger data", 32'h2CE, {22'h0, dmaD});
      $display("test trigger done");
      wb(1'b1, OFS_CMD, 32'h1);
      rd(OFS_MODE, 32'h0);
      rd(OFS_CHEN_STATE, 32'h0);
      $display("test soft reset done");
      finish_test();
   end
endmodule : adcc_ctrl_top_tb

// [rtl/adcc_clk_div.sv]
// Purpose: conversion clock tick generator from the master clock
// Assumes: divider value may change at any time
// Notes: tick period is 2 * (divider + 1) master clock cycles
`timescale 1ns/1ps
module adcc_clk_div #(
   parameter int DW = adcc_pkg::DIV_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control
   input wire logic [DW-1:0] divider,
   // tick out
   adcc_tick_if.src tk
);
   import adcc_pkg::*;
   logic [DW-1:0] cnt;
   logic phase;
   wire halfEnd = (cnt >= divider);
   initial begin
      if (DW < 1 || DW > 16) $error("divider width out of range");
   end
   // ==================================================================
   // half period counter, tick on every second half
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt <= '0;
         phase <= 1'b0;
         tk.tick <= 1'b0;
      end else begin
         tk.tick <= halfEnd & phase;
         phase <= phase ^ halfEnd;
         cnt <= halfEnd ? '0 : DW'(cnt + 1'b1);
      end
   end
endmodule : adcc_clk_div

// [rtl/adcc_ctrl_top.sv]
// Purpose: control and status logic of a four-channel converter
// Assumes: analog cell and DMA counters are logic on ref_clk
// Notes: trigger pins are synchronised; registers on Wishbone
//
// Functional notes
// - command soft reset bit set returns whole block to reset state
// - command start bit set begins a conversion sequence
// - trigger enable clear: hardware triggers ignored, software only
// - trigger enable set: starts accepted from selected hardware source
// - select 0,1,2 pick timer outputs, 6 external pin, rest reserved
// - conversion clock is master clock over 2 * (divider + 1)
// - start-up wait lasts 8 * (start-up field + 1) ticks
// - sample-and-hold lasts sample field + 1 ticks
// - channel enable set register: ones enable, zeros no effect
// - channel enable clear register: ones disable, zeros no effect
// - channel state bits read one for enabled channels
// - done flag reads one only if enabled and conversion complete
// - channel overrun flag set on overrun since last flags read
// - result ready set on any result, cleared by last-result read
// - global overrun set when result arrives while ready still set
// - buffer end set once rx count hit zero since count write
// - buffers full reads one while both rx counts are zero
// - low resolution gives 8-bit results and byte DMA transfers
// - sleep: a start powers up and waits start-up only if unpowered, converts, then powers down
// - result read clears its done flag; last read clears ready too
// - flags read clears all channel overruns and global overrun
`timescale 1ns/1ps
module adcc_ctrl_top #(
   parameter int NUM_CH = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [adcc_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [adcc_pkg::DATA_W-1:0] wb_dat_i,
   output logic [adcc_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // trigger pins
   input wire logic [2:0] timerOutA,
   input wire logic extTrigPin,
   // analog cell
   input wire logic [adcc_pkg::RESULT_W-1:0] cellResult,
   output logic cellPowerOn,
   output logic cellSample,
   output logic cellConvert,
   output logic [1:0] cellChannel,
   // peripheral dma channel
   input wire logic rxCountZero,
   input wire logic rxNextCountZero,
   input wire logic rxCountWrite,
   input wire logic dmaTaken,
   output logic dmaRequest,
   output logic dmaByteMode,
   output logic [adcc_pkg::RESULT_W-1:0] dmaData
);
   import adcc_pkg::*;
   initial begin
      if (NUM_CH != 4) $error("register layout serves four channels");
   end
   // ==================================================================
   // functions
   function automatic logic [31:0] laneMask(input logic [3:0] sel);
      laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : laneMask
   // first enabled channel at or above start; bit 2 flags none found
   function automatic logic [2:0] pickCh(input logic [3:0] en,
                                         input logic [2:0] start);
      logic [2:0] r;
      r = 3'h4;
      for (int i = 3; i >= 0; i--) begin
         if (en[i] && 3'(i) >= start) r = 3'(i);
      end
      pickCh = r;
   endfunction : pickCh
   // ==================================================================
   // state
   logic softRstPend;
   logic swStart;
   logic [31:0] mode;
   logic [3:0] chEn;
   logic [3:0] eoc;
   logic [3:0] ovr;
   logic result_ready_flag;
   logic govr;
   logic bufEnd;
   logic bufFull;
   logic [RESULT_W-1:0] result [4];
   logic [RESULT_W-1:0] lastRes;
   logic [1:0] lastCh;
   logic [1:0] curCh;
   logic powered;
   adcc_seq_e state;
   logic tLoad;
   logic [TICK_W-1:0] tVal;
   logic tDone;
   logic [3:0] trigMeta;
   logic [3:0] trigSync;
   logic [3:0] trigPrev;
   adcc_tick_if tickBus ();
   wire coreRstN = rst_n & ~softRstPend;
   // ==================================================================
   // mode fields
   wire hw_trigger_enable = mode[MODE_TRIG_EN_BIT];
   wire [TSEL_W-1:0] hw_trigger_select = mode[MODE_TRIG_SEL_LSB +: TSEL_W];
   wire low_resolution_select = mode[MODE_RES_BIT];
   wire sleepMode = mode[MODE_SLEEP_BIT];
   wire [DIV_W-1:0] divField = mode[MODE_DIV_LSB +: DIV_W];
   wire [STARTUP_W-1:0] suField = mode[MODE_STARTUP_LSB +: STARTUP_W];
   wire [SH_W-1:0] shField = mode[MODE_SH_LSB +: SH_W];
   wire [TICK_W-1:0] suTicks =
      TICK_W'((32'(suField) + 1) * STARTUP_MULT);
   wire [TICK_W-1:0] shTicks = TICK_W'(32'(shField) + 1);
   // ==================================================================
   // bus decode
   wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = acc & wb_we_i;
   wire rd = acc & ~wb_we_i;
   wire [31:0] wMask = laneMask(wb_sel_i);
   wire [31:0] wData = wb_dat_i & wMask;
   wire [7:0] adr = wb_adr_i;
   wire hitCmd = adr == OFS_CMD;
   wire hitMode = adr == OFS_MODE;
   wire hitSet = adr == OFS_CHEN_SET;
   wire hitClr = adr == OFS_CHEN_CLR;
   wire hitState = adr == OFS_CHEN_STATE;
   wire hitFlags = adr == OFS_FLAGS;
   wire hitLast = adr == OFS_LAST;
   wire hitRes = adr[7:4] == OFS_RESULT0[7:4] && adr[1:0] == 2'b00;
   wire [1:0] resIdx = adr[3:2];
   wire flagsRd = rd & hitFlags;
   wire lastRd = (rd & hitLast) | dmaTaken;
   wire resRd = rd & hitRes;
   wire [3:0] chSet = (wr & hitSet) ? wData[3:0] : 4'h0;
   wire [3:0] chClr = (wr & hitClr) ? wData[3:0] : 4'h0;
   wire [3:0] doneView = eoc & chEn;
   wire [31:0] flagsWord = 32'(doneView) << FLG_DONE_LSB
      | 32'(ovr) << FLG_OVR_LSB
      | 32'(result_ready_flag) << FLG_READY_BIT
      | 32'(govr) << FLG_GOVR_BIT
      | 32'(bufEnd) << FLG_BUFEND_BIT
      | 32'(bufFull) << FLG_BUFFULL_BIT;
   wire [31:0] rdMux =
      hitMode ? mode :
      hitState ? 32'(chEn) :
      hitFlags ? flagsWord :
      hitLast ? 32'(lastRes) :
      hitRes ? 32'(result[resIdx]) : 32'h0000_0000;
   // ==================================================================
   // trigger selection
   wire [3:0] trigRise = trigSync & ~trigPrev;
   wire selValid = hw_trigger_select == TSEL_TIMER0 || hw_trigger_select == TSEL_TIMER1
      || hw_trigger_select == TSEL_TIMER2 || hw_trigger_select == TSEL_EXT;
   wire hwRise = selValid &&
      (hw_trigger_select == TSEL_EXT ? trigRise[3] : trigRise[hw_trigger_select[1:0]]);
   wire startReq = swStart | (hw_trigger_enable & hwRise);
   // ==================================================================
   // sequencer decode
   wire [2:0] firstCh = pickCh(chEn, 3'h0);
   wire [2:0] nextCh = pickCh(chEn, 3'(curCh) + 3'h1);
   wire convDone = (state == SEQ_CONVERT) & tDone;
   wire [3:0] eocSet = convDone ? 4'(4'h1 << curCh) : 4'h0;
   wire [3:0] eocClr = (resRd ? 4'(4'h1 << resIdx) : 4'h0)
      | (lastRd ? 4'(4'h1 << lastCh) : 4'h0);
   wire [RESULT_W-1:0] cellData = low_resolution_select ?
      RESULT_W'(cellResult[LOW_RESOLUTION_SELECT_W-1:0]) : cellResult;
   // ==================================================================
   // submodules
   adcc_clk_div #(.DW(DIV_W)) uDiv (
      .ref_clk(ref_clk),
      .rst_n(coreRstN),
      .divider(divField),
      .tk(tickBus.src)
   );
   adcc_tick_timer #(.TW(TICK_W)) uTimer (
      .ref_clk(ref_clk),
      .rst_n(coreRstN),
      .tk(tickBus.snk),
      .load(tLoad),
      .loadVal(tVal),
      .done(tDone)
   );
   // ==================================================================
   // bus slave
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         softRstPend <= 1'b0;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= rd ? rdMux : 32'h0000_0000;
         softRstPend <= wr & hitCmd & wData[CMD_SOFT_RESET_BIT];
      end
   end
   // ==================================================================
   // control registers
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         mode <= MODE_RESET;
         chEn <= 4'h0;
         swStart <= 1'b0;
      end else begin
         swStart <= wr & hitCmd & wData[CMD_START_BIT];
         if (wr && hitMode) begin
            mode <= (mode & ~(wMask & MODE_WRITE_MASK))
               | (wData & MODE_WRITE_MASK);
         end
         chEn <= (chEn | chSet) & ~chClr;
      end
   end
   // ==================================================================
   // trigger pin synchronisers
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         trigMeta <= 4'h0;
         trigSync <= 4'h0;
         trigPrev <= 4'h0;
      end else begin
         trigMeta <= {extTrigPin, timerOutA};
         trigSync <= trigMeta;
         trigPrev <= trigSync;
      end
   end
   // ==================================================================
   // status flags; a set in the clearing cycle wins
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         eoc <= 4'h0;
         ovr <= 4'h0;
         result_ready_flag <= 1'b0;
         govr <= 1'b0;
         bufEnd <= BUFEND_RESET;
         bufFull <= BUFFULL_RESET;
      end else begin
         eoc <= eocSet | (eoc & ~eocClr);
         ovr <= (eocSet & eoc) | (ovr & ~{4{flagsRd}});
         result_ready_flag <= convDone | (result_ready_flag & ~lastRd);
         govr <= (convDone & result_ready_flag) | (govr & ~flagsRd);
         bufEnd <= rxCountZero | (bufEnd & ~rxCountWrite);
         bufFull <= rxCountZero & rxNextCountZero;
      end
   end
   // ==================================================================
   // results and dma
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         result <= '{default: '0};
         lastRes <= '0;
         lastCh <= 2'h0;
         dmaRequest <= 1'b0;
         dmaByteMode <= 1'b0;
         dmaData <= '0;
      end else begin
         dmaRequest <= convDone & ~result_ready_flag;
         dmaByteMode <= low_resolution_select;
         if (convDone) begin
            result[curCh] <= cellData;
            lastRes <= cellData;
            lastCh <= curCh;
            dmaData <= cellData;
         end
      end
   end
   // ==================================================================
   // conversion sequencer
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         state <= SEQ_IDLE;
         curCh <= 2'h0;
         powered <= 1'b0;
         tLoad <= 1'b0;
         tVal <= '0;
      end else begin
         tLoad <= 1'b0;
         case (state)
            SEQ_IDLE: begin
               // starts outside idle are dropped
               if (startReq && !firstCh[2]) begin
                  tLoad <= 1'b1;
                  if (!powered) begin
                     state <= SEQ_STARTUP;
                     tVal <= suTicks;
                  end else begin
                     state <= SEQ_SAMPLE;
                     curCh <= firstCh[1:0];
                     tVal <= shTicks;
                  end
               end
            end
            SEQ_STARTUP: begin
               if (tDone) begin
                  powered <= 1'b1;
                  if (firstCh[2]) begin
                     state <= SEQ_IDLE;
                  end else begin
                     state <= SEQ_SAMPLE;
                     curCh <= firstCh[1:0];
                     tLoad <= 1'b1;
                     tVal <= shTicks;
                  end
               end
            end
            SEQ_SAMPLE: begin
               if (tDone) begin
                  state <= SEQ_CONVERT;
                  tLoad <= 1'b1;
                  tVal <= TICK_W'(CONV_TICKS);
               end
            end
            SEQ_CONVERT: begin
               if (tDone) begin
                  if (nextCh[2]) begin
                     state <= SEQ_IDLE;
                     powered <= ~sleepMode & powered;
                  end else begin
                     state <= SEQ_SAMPLE;
                     curCh <= nextCh[1:0];
                     tLoad <= 1'b1;
                     tVal <= shTicks;
                  end
               end
            end
            default: state <= SEQ_IDLE;
         endcase
      end
   end
   // ==================================================================
   // analog cell controls
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         cellPowerOn <= 1'b0;
         cellSample <= 1'b0;
         cellConvert <= 1'b0;
         cellChannel <= 2'h0;
      end else begin
         cellPowerOn <= powered | (state == SEQ_STARTUP);
         cellSample <= state == SEQ_SAMPLE;
         cellConvert <= state == SEQ_CONVERT;
         cellChannel <= curCh;
      end
   end
   // ==================================================================
   // assertion helpers
   logic [7:0] gapCnt;
   logic gapOk;
   logic [TICK_W-1:0] phaseTicks;
   adcc_seq_e prevState;
   always_ff @(posedge ref_clk) begin
      if (!coreRstN) begin
         gapCnt <= 8'h00;
         gapOk <= 1'b0;
         phaseTicks <= '0;
         prevState <= SEQ_IDLE;
      end else begin
         prevState <= state;
         gapCnt <= tickBus.tick ? 8'h01 : 8'(gapCnt + 1'b1);
         gapOk <= (gapOk | tickBus.tick) & ~(wr & hitMode);
         if (state != prevState) begin
            phaseTicks <= '0;
         end else if (tickBus.tick && !tLoad) begin
            phaseTicks <= TICK_W'(phaseTicks + 1'b1);
         end
      end
   end
   // ==================================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   soft_reset_a: assert property (softRstPend |=>
      mode == MODE_RESET && chEn == 4'h0 && state == SEQ_IDLE)
      else $error("soft reset did not clear block");
   sw_start_a: assert property (
      swStart && state == SEQ_IDLE && chEn != 4'h0 |=> state != SEQ_IDLE)
      else $error("software start not taken");
   hw_ignore_a: assert property (
      state == SEQ_IDLE && !swStart && !hw_trigger_enable |=> state == SEQ_IDLE)
      else $error("sequence began without a start");
   hw_accept_a: assert property (
      state == SEQ_IDLE && hw_trigger_enable && hwRise && chEn != 4'h0
      |=> state != SEQ_IDLE)
      else $error("hardware trigger not taken");
   trig_reserved_a: assert property (!selValid |-> !hwRise)
      else $error("reserved trigger code produced a start");
   div_period_a: assert property (
      tickBus.tick && gapOk |-> 32'(gapCnt) == 2 * (32'(divField) + 1))
      else $error("conversion clock period wrong");
   startup_len_a: assert property (
      state == SEQ_STARTUP && tDone |-> phaseTicks == suTicks)
      else $error("start-up wait length wrong");
   sample_len_a: assert property (
      state == SEQ_SAMPLE && tDone |-> phaseTicks == shTicks)
      else $error("sample-and-hold length wrong");
   chan_enable_a: assert property (
      wr && hitSet && !(wr && hitClr) |=> (chEn & $past(chSet)) == $past(chSet))
      else $error("channel enable write lost");
   ready_set_a: assert property (convDone |=> result_ready_flag [*1] ##1 1)
      else $error("result ready not set by a result");
   govr_set_a: assert property (convDone && result_ready_flag |=> govr)
      else $error("global overrun missed");
   ovr_clear_a: assert property (
      flagsRd && !convDone |=> ovr == 4'h0 && !govr)
      else $error("flags read left overruns set");
   low_resolution_select_data_a: assert property (
      convDone && low_resolution_select |=> lastRes[RESULT_W-1:LOW_RESOLUTION_SELECT_W] == 2'b00)
      else $error("upper result bits set in 8-bit mode");
endmodule : adcc_ctrl_top

// [rtl/adcc_pkg.sv]
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: all offsets, fields, reset values and tick counts live here
package adcc_pkg;
   // ==================================================================
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // ==================================================================
   // register offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_CHEN_SET = 8'h10;
   localparam logic [7:0] OFS_CHEN_CLR = 8'h14;
   localparam logic [7:0] OFS_CHEN_STATE = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_LAST = 8'h20;
   localparam logic [7:0] OFS_RESULT0 = 8'h30;
   // ==================================================================
   // field positions
   localparam int CMD_SOFT_RESET_BIT = 0;
   localparam int CMD_START_BIT = 1;
   localparam int MODE_TRIG_EN_BIT = 0;
   localparam int MODE_TRIG_SEL_LSB = 1;
   localparam int MODE_RES_BIT = 4;
   localparam int MODE_SLEEP_BIT = 5;
   localparam int MODE_DIV_LSB = 8;
   localparam int MODE_STARTUP_LSB = 16;
   localparam int MODE_SH_LSB = 24;
   localparam int TSEL_W = 3;
   localparam int DIV_W = 6;
   localparam int STARTUP_W = 5;
   localparam int SH_W = 4;
   localparam int FLG_DONE_LSB = 0;
   localparam int FLG_OVR_LSB = 8;
   localparam int FLG_READY_BIT = 16;
   localparam int FLG_GOVR_BIT = 17;
   localparam int FLG_BUFEND_BIT = 18;
   localparam int FLG_BUFFULL_BIT = 19;
   // ==================================================================
   // reset values and masks
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] MODE_WRITE_MASK = 32'h0F1F_3F3F;
   localparam logic BUFEND_RESET = 1'b1;
   localparam logic BUFFULL_RESET = 1'b1;
   // ==================================================================
   // trigger source codes
   localparam logic [2:0] TSEL_TIMER0 = 3'h0;
   localparam logic [2:0] TSEL_TIMER1 = 3'h1;
   localparam logic [2:0] TSEL_TIMER2 = 3'h2;
   localparam logic [2:0] TSEL_EXT = 3'h6;
   // ==================================================================
   // timing in conversion clock ticks, tick counter and result widths in bits
   localparam int CONV_TICKS = 10;
   localparam int STARTUP_MULT = 8;
   localparam int TICK_W = 9;
   localparam int RESULT_W = 10;
   localparam int LOW_RESOLUTION_SELECT_W = 8;
   // ==================================================================
   // sequencer states
   typedef enum logic [2:0] {
      SEQ_IDLE, SEQ_STARTUP, SEQ_SAMPLE, SEQ_CONVERT
   } adcc_seq_e;
endpackage : adcc_pkg

// [rtl/adcc_tick_if.sv]
// Purpose: carries the conversion clock tick between block modules
// Assumes: one clock domain, tick is a one-cycle pulse
// Notes: src drives the tick, snk consumes it
`timescale 1ns/1ps
interface adcc_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface : adcc_tick_if

// [rtl/adcc_tick_timer.sv]
// Purpose: counts a loaded number of conversion clock ticks
// Assumes: load is a one-cycle pulse, count of zero never completes
// Notes: done pulses the cycle after the last counted tick
`timescale 1ns/1ps
module adcc_tick_timer #(
   parameter int TW = adcc_pkg::TICK_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // tick in
   adcc_tick_if.snk tk,
   // control
   input wire logic load,
   input wire logic [TW-1:0] loadVal,
   output logic done
);
   import adcc_pkg::*;
   logic [TW-1:0] cnt;
   wire lastTick = tk.tick && (cnt == TW'(1));
   initial begin
      if (TW < 4) $error("timer too narrow for conversion length");
   end
   // ==================================================================
   // down counter
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt <= '0;
         done <= 1'b0;
      end else begin
         done <= lastTick & ~load;
         if (load) begin
            cnt <= loadVal;
         end else if (tk.tick && cnt != '0) begin
            cnt <= TW'(cnt - 1'b1);
         end
      end
   end
endmodule : adcc_tick_timer
